// *** rtl/pcr_pkg.sv ***
// constants and carrier types for the configuration header register bank
package pcr_pkg;

  // byte offsets of the header fields
  localparam logic [7:0] OFS_MAKER    = 8'h00;
  localparam logic [7:0] OFS_PART     = 8'h02;
  localparam logic [7:0] OFS_COMMAND  = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h06;
  localparam logic [7:0] OFS_REVISION = 8'h08;
  localparam logic [7:0] OFS_CLASS    = 8'h09;
  localparam logic [7:0] OFS_CACHE    = 8'h0C;
  localparam logic [7:0] OFS_TENURE   = 8'h0D;

  // dword indices derived from the byte offsets
  localparam logic [5:0] DW_ID       = OFS_MAKER[7:2];
  localparam logic [5:0] DW_CMDSTAT  = OFS_COMMAND[7:2];
  localparam logic [5:0] DW_CLASS    = OFS_REVISION[7:2];
  localparam logic [5:0] DW_CACHE    = OFS_CACHE[7:2];

  // command bit positions
  localparam int CMD_IO     = 0;
  localparam int CMD_MEM    = 1;
  localparam int CMD_MASTER = 2;
  localparam int CMD_WINV   = 4;
  localparam int CMD_PAR    = 6;
  localparam int CMD_SERR   = 8;

  // status bit positions
  localparam int ST_NEWCAP  = 4;
  localparam int ST_MPAR    = 8;
  localparam int ST_TIMING  = 9;
  localparam int ST_TABORT  = 12;
  localparam int ST_MABORT  = 13;
  localparam int ST_SERR    = 14;
  localparam int ST_DPE     = 15;

  // masks and reset values
  localparam logic [15:0] CMD_WR_MASK  = 16'h0157;
  localparam logic [15:0] CMD_D2_MASK  = 16'h0147;
  localparam logic [15:0] ST_W1C_MASK  = 16'hF100;
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  localparam logic [15:0] ST_RESET     = 16'h0000;
  localparam logic [1:0]  SEL_MEDIUM   = 2'h1;
  localparam logic [23:0] CLASS_VALUE  = 24'h010000;
  localparam logic [7:0]  CLS_RESET    = 8'h00;
  localparam logic [7:0]  LT_RESET     = 8'h00;
  localparam logic [31:0] RDATA_RESET  = 32'h00000000;

  // bus commands chosen by the master
  localparam logic [3:0] BC_MEM_READ   = 4'h6;
  localparam logic [3:0] BC_MEM_WRITE  = 4'h7;
  localparam logic [3:0] BC_READ_MULT  = 4'hC;
  localparam logic [3:0] BC_READ_LINE  = 4'hE;
  localparam logic [3:0] BC_WRITE_INV  = 4'hF;

  // one configuration access
  typedef struct packed {
    logic        write;
    logic [2:0]  func;
    logic [5:0]  dword;
    logic [3:0]  byteEn;
    logic [31:0] wdata;
  } pcr_cfg_req_t;

  // one-cycle events reported by the bus engine
  typedef struct packed {
    logic dataParityErr;
    logic sysErrReq;
    logic addrParityErr;
    logic masterAbort;
    logic specialCycle;
    logic targetAbort;
    logic perrSeen;
    logic perrAsMaster;
  } pcr_events_t;

endpackage

// *** rtl/pcr_cfg_header.sv ***
// configuration header registers, offsets 00h to 0Dh, of one function
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// RULE1 - zero command detaches all but configuration
// RULE2 - serr enable gates driver, address parity
// RULE3 - parity response gates checking, generation always
// RULE4 - write-invalidate needs command and core enable
// RULE5 - master enable gates bus master starts
// RULE6 - memory enable gates memory claims
// RULE7 - io enable gates io claims
// RULE8 - power state D2 suppresses enables; code leaves write-invalidate (bit 4) enabled in D2
// RULE9 - status bits clear on write one
// RULE10 - data parity error always sets detect
// RULE11 - asserted system error sets signaled bit
// RULE12 - master abort, not special, sets bit
// RULE13 - target abort sets received bit
// RULE14 - select timing reads fixed medium
// RULE15 - master parity reported needs three conditions
// RULE16 - capabilities bit reads one
// RULE17 - identity codes fixed read only
// RULE18 - class code reads 010000h
// RULE19 - cache line steers master command choice
// RULE20 - non power of two disables performance
// RULE21 - tenure timer writable, resets zero
// RULE22 - software picks a sensible tenure value
// RULE23 - selected by idsel and function number
// RULE24 - unsupported registers read zero
// RULE25 - reserved command, status bits read zero
module pcr_cfg_header #(
  parameter logic [2:0]  FUNC_NUM   = 3'h0,
  parameter logic        ENHANCED   = 1'b1,
  parameter logic [15:0] MAKER_CODE = 16'hA5A5, // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h5A5A, // arbitrary value
  parameter logic [7:0]  REV_CODE   = 8'h01     // arbitrary value
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 cfgValid,
  input  wire pcr_pkg::pcr_cfg_req_t cfgReq,
  output var  logic                 cfgAck,
  output var  logic [31:0]          cfgRdata,
  input  wire logic                 powerStateD2,
  input  wire logic                 coreWriteInvalidateEnable,
  input  wire pcr_pkg::pcr_events_t busEvents,
  input  wire logic                 ioHit,
  input  wire logic                 memHit,
  output var  logic                 ioClaim,
  output var  logic                 memClaim,
  input  wire logic                 masterStartReq,
  input  wire logic                 masterIsWrite,
  input  wire logic [7:0]           masterWords,
  output var  logic                 masterStart,
  output var  logic [3:0]           masterCmd,
  input  wire logic                 masterFrameActive,
  output var  logic                 tenureExpired,
  output var  logic                 parityCheckEn,
  output var  logic                 parityGenEn,
  output var  logic                 serrOut,
  output var  logic                 serrOeN
);

  logic [15:0] command_r;
  logic [15:0] status_r;
  logic [7:0]  cacheline_r;
  logic [7:0]  tenure_r;
  logic [7:0]  tenureCnt_r;
  logic [15:0] cmdEff;
  logic        cfgHit;
  logic        cfgWr;
  logic        assertSerr;
  logic        perfOk;
  logic        winvOk;
  logic [15:0] statusClr;
  logic [15:0] statusSet;
  logic [15:0] cacheMerged;
  logic [31:0] rdata_nxt;
  logic [3:0]  cmd_nxt;

  // byte-lane merge of a 16-bit half with its two enables
  function automatic logic [15:0] mergeHalf(input logic [15:0] old,
                                            input logic [15:0] wr,
                                            input logic [1:0]  be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wr[7:0];
    end
    if (be[1]) begin
      res[15:8] = wr[15:8];
    end
    return res;
  endfunction

  // nonzero power of two test for the cache line size
  function automatic logic isPow2(input logic [7:0] v);
    return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction

  // access decode: idsel qualified request for our function only
  assign cfgHit = cfgValid && (cfgReq.func == FUNC_NUM); // see RULE23
  assign cfgWr  = cfgHit && cfgReq.write;

  // D2 hides all enables but write-invalidate without losing what software stored
  assign cmdEff = (ENHANCED && powerStateD2) ?
                  (command_r & ~pcr_pkg::CMD_D2_MASK) : command_r; // see RULE8

  // system error drive only with its enable; address parity also needs
  // parity response
  assign assertSerr = cmdEff[pcr_pkg::CMD_SERR] &&
                      (busEvents.sysErrReq ||
                       (busEvents.addrParityErr &&
                        cmdEff[pcr_pkg::CMD_PAR])); // see RULE2

  assign perfOk = isPow2(cacheline_r); // see RULE20
  assign winvOk = cmdEff[pcr_pkg::CMD_WINV] &&
                  coreWriteInvalidateEnable; // see RULE4

  // write-one-to-clear from the upper half of dword 1
  assign statusClr = (cfgWr && cfgReq.dword == pcr_pkg::DW_CMDSTAT) ?
                     (cfgReq.wdata[31:16] &
                      {{8{cfgReq.byteEn[3]}}, {8{cfgReq.byteEn[2]}}} &
                      pcr_pkg::ST_W1C_MASK) : 16'h0000; // see RULE9

  // sticky event sources
  always_comb begin
    statusSet = 16'h0000;
    statusSet[pcr_pkg::ST_DPE]    = busEvents.dataParityErr; // see RULE10
    statusSet[pcr_pkg::ST_SERR]   = !serrOeN; // see RULE11
    statusSet[pcr_pkg::ST_MABORT] = busEvents.masterAbort &&
                                    !busEvents.specialCycle; // see RULE12
    statusSet[pcr_pkg::ST_TABORT] = busEvents.targetAbort; // see RULE13
    statusSet[pcr_pkg::ST_MPAR]   = busEvents.perrSeen &&
                                    busEvents.perrAsMaster &&
                                    cmdEff[pcr_pkg::CMD_PAR]; // see RULE15
  end

  assign cacheMerged = mergeHalf({tenure_r, cacheline_r},
                                 cfgReq.wdata[15:0], cfgReq.byteEn[1:0]);

  // command register; reserved bits never stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      command_r <= pcr_pkg::CMD_RESET;
    end else if (cfgWr && cfgReq.dword == pcr_pkg::DW_CMDSTAT) begin
      command_r <= mergeHalf(command_r, cfgReq.wdata[15:0],
                             cfgReq.byteEn[1:0]) &
                   pcr_pkg::CMD_WR_MASK; // see RULE25
    end
  end

  // status: a set in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= pcr_pkg::ST_RESET;
    end else begin
      status_r <= (status_r & ~statusClr) | statusSet; // see RULE9
    end
  end

  // cache line size and tenure value share dword 3
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cacheline_r <= pcr_pkg::CLS_RESET;
      tenure_r    <= pcr_pkg::LT_RESET; // see RULE21
    end else if (cfgWr && cfgReq.dword == pcr_pkg::DW_CACHE) begin
      cacheline_r <= cacheMerged[7:0];
      tenure_r    <= cacheMerged[15:8];
    end
  end

  // read mux; anything outside the four dwords reads zero
  always_comb begin
    rdata_nxt = 32'h00000000; // see RULE24
    case (cfgReq.dword)
      pcr_pkg::DW_ID: begin
        rdata_nxt = {PART_CODE, MAKER_CODE}; // see RULE17
      end
      pcr_pkg::DW_CMDSTAT: begin
        rdata_nxt = {status_r[15:12], 1'b0, pcr_pkg::SEL_MEDIUM,
                     status_r[8], 3'b000, 1'b1, 4'h0,
                     command_r}; // see RULE14 RULE16 RULE25
      end
      pcr_pkg::DW_CLASS: begin
        rdata_nxt = {pcr_pkg::CLASS_VALUE, REV_CODE}; // see RULE18
      end
      pcr_pkg::DW_CACHE: begin
        rdata_nxt = {16'h0000, tenure_r, cacheline_r};
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  // answer one cycle after the request; writes answer with zero data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgAck   <= 1'b0;
      cfgRdata <= pcr_pkg::RDATA_RESET;
    end else begin
      cfgAck   <= cfgHit;
      cfgRdata <= (cfgHit && !cfgReq.write) ? rdata_nxt : 32'h00000000;
    end
  end

  // target claims follow the decode enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ioClaim  <= 1'b0;
      memClaim <= 1'b0;
    end else begin
      ioClaim  <= ioHit && cmdEff[pcr_pkg::CMD_IO]; // see RULE7 RULE1
      memClaim <= memHit && cmdEff[pcr_pkg::CMD_MEM]; // see RULE6 RULE1
    end
  end

  // command choice from the cache line; plain commands when unusable
  always_comb begin
    if (masterIsWrite) begin
      cmd_nxt = (perfOk && winvOk && masterWords >= cacheline_r) ?
                pcr_pkg::BC_WRITE_INV : pcr_pkg::BC_MEM_WRITE; // see RULE19
    end else if (perfOk && {1'b0, masterWords} >= {cacheline_r, 1'b0}) begin
      cmd_nxt = pcr_pkg::BC_READ_MULT;
    end else if (perfOk && masterWords >= cacheline_r) begin
      cmd_nxt = pcr_pkg::BC_READ_LINE;
    end else begin
      cmd_nxt = pcr_pkg::BC_MEM_READ;
    end
  end

  // master start gate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      masterStart <= 1'b0;
      masterCmd   <= pcr_pkg::BC_MEM_READ;
    end else begin
      masterStart <= masterStartReq &&
                     cmdEff[pcr_pkg::CMD_MASTER]; // see RULE5 RULE1
      if (masterStartReq) begin
        masterCmd <= cmd_nxt;
      end
    end
  end

  // tenure count reloads while idle, so a new value takes effect from the next frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tenureCnt_r   <= pcr_pkg::LT_RESET;
      tenureExpired <= 1'b0;
    end else if (!masterFrameActive) begin
      tenureCnt_r   <= tenure_r; // see RULE21
      tenureExpired <= 1'b0;
    end else begin
      if (tenureCnt_r != 8'h00) begin
        tenureCnt_r <= tenureCnt_r - 8'h01;
      end
      tenureExpired <= (tenureCnt_r == 8'h00);
    end
  end

  // parity and open-drain system error pin; driven level is always low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parityCheckEn <= 1'b0;
      parityGenEn   <= 1'b1;
      serrOut       <= 1'b0;
      serrOeN       <= 1'b1;
    end else begin
      parityCheckEn <= cmdEff[pcr_pkg::CMD_PAR]; // see RULE3
      parityGenEn   <= 1'b1; // see RULE3
      serrOut       <= 1'b0;
      serrOeN       <= !assertSerr; // see RULE2
    end
  end

  // checks; all on the one clock, quiet during reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_cmd_zero;
    command_r == 16'h0000 |=> !ioClaim && !memClaim && !masterStart;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) // see RULE1
    else $error("claim or start with zero command");
  property p_serr_gate;
    !command_r[pcr_pkg::CMD_SERR] |=> serrOeN;
  endproperty
  a_serr_gate: assert property (p_serr_gate) // see RULE2
    else $error("serr driven while disabled");
  property p_par_gen;
    !cmdEff[pcr_pkg::CMD_PAR] |=> parityGenEn && !parityCheckEn;
  endproperty
  a_par_gen: assert property (p_par_gen) // see RULE3
    else $error("parity check or generation wrong");
  property p_winv;
    masterStartReq && masterIsWrite && !winvOk
      |=> masterCmd != pcr_pkg::BC_WRITE_INV;
  endproperty
  a_winv: assert property (p_winv) // see RULE4
    else $error("write-invalidate without both enables");
  property p_master_gate;
    masterStart |-> $past(cmdEff[pcr_pkg::CMD_MASTER] && masterStartReq);
  endproperty
  a_master_gate: assert property (p_master_gate) // see RULE5
    else $error("master start without enable");
  property p_mem_claim;
    memClaim |-> $past(memHit && cmdEff[pcr_pkg::CMD_MEM]);
  endproperty
  a_mem_claim: assert property (p_mem_claim) // see RULE6
    else $error("memory claim without enable");
  property p_io_claim;
    ioHit && command_r[pcr_pkg::CMD_IO] && !(ENHANCED && powerStateD2)
      |=> ioClaim;
  endproperty
  a_io_claim: assert property (p_io_claim) // see RULE7
    else $error("io access not claimed");
  property p_d2;
    ENHANCED && powerStateD2 |=> !ioClaim && !memClaim && !masterStart
                                 && serrOeN && !parityCheckEn;
  endproperty
  a_d2: assert property (p_d2) // see RULE8
    else $error("enable active in D2");
  property p_w1c;
    statusClr[pcr_pkg::ST_TABORT] && !busEvents.targetAbort
      |=> !status_r[pcr_pkg::ST_TABORT];
  endproperty
  a_w1c: assert property (p_w1c) // see RULE9
    else $error("status bit not cleared");
  property p_dpe;
    busEvents.dataParityErr |=> status_r[pcr_pkg::ST_DPE];
  endproperty
  a_dpe: assert property (p_dpe) // see RULE10
    else $error("parity error not recorded");
  sequence s_serr_cause;
    assertSerr ##1 !serrOeN;
  endsequence
  property p_sse;
    s_serr_cause |=> status_r[pcr_pkg::ST_SERR];
  endproperty
  a_sse: assert property (p_sse) // see RULE11
    else $error("serr not recorded");
  property p_mabort;
    $rose(status_r[pcr_pkg::ST_MABORT])
      |-> $past(busEvents.masterAbort && !busEvents.specialCycle);
  endproperty
  a_mabort: assert property (p_mabort) // see RULE12
    else $error("master abort bit without cause");
  property p_dpr;
    $rose(status_r[pcr_pkg::ST_MPAR]) |-> $past(busEvents.perrSeen &&
      busEvents.perrAsMaster && cmdEff[pcr_pkg::CMD_PAR]);
  endproperty
  a_dpr: assert property (p_dpr) // see RULE15
    else $error("master parity bit without all conditions");
  property p_perf;
    masterStartReq && !perfOk |=> masterCmd == pcr_pkg::BC_MEM_READ ||
                                  masterCmd == pcr_pkg::BC_MEM_WRITE;
  endproperty
  a_perf: assert property (p_perf) // see RULE20
    else $error("performance command with bad cache line");
  sequence s_frame_zero;
    !masterFrameActive && tenure_r == 8'h00 ##1 masterFrameActive;
  endsequence
  property p_tenure;
    s_frame_zero |=> tenureExpired;
  endproperty
  a_tenure: assert property (p_tenure) // see RULE21
    else $error("zero tenure did not expire");
  property p_unsup;
    cfgHit && cfgReq.dword > pcr_pkg::DW_CACHE |=> cfgAck && cfgRdata == 0;
  endproperty
  a_unsup: assert property (p_unsup) // see RULE24
    else $error("unsupported register not zero");

endmodule

`default_nettype wire

// *** tb/pcr_host_model.sv ***
// host bridge model issuing configuration reads and writes
`timescale 1ns/1ns
`default_nettype none

module pcr_host_model (
  input  wire logic                  clk,
  output var  logic                  cfgValid,
  output var  pcr_pkg::pcr_cfg_req_t cfgReq,
  input  wire logic                  cfgAck,
  input  wire logic [31:0]           cfgRdata
);

  // bus idle at time zero
  initial begin
    cfgValid = 1'b0;
    cfgReq   = '0;
  end

  // one-edge request; the answer is fixed at the taking edge and read 1 ns later
  task automatic access(input logic wr, input logic [2:0] fn,
                        input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic ack,
                        output logic [31:0] rd);
    @(posedge clk);
    cfgValid <= 1'b1;
    cfgReq   <= '{write: wr, func: fn, dword: dw, byteEn: be, wdata: wd};
    @(posedge clk);
    cfgValid <= 1'b0;
    // released lines never keep the last request visible
    cfgReq   <= ~cfgReq;
    #1;
    ack = cfgAck;
    rd  = cfgRdata;
  endtask

endmodule

`default_nettype wire

// *** tb/pcr_cfg_header_tb.sv ***
// self-checking bench for the configuration header register bank
`timescale 1ns/1ns
`default_nettype none

module pcr_cfg_header_tb;

  localparam logic [15:0] MK = 16'hC3C3; // arbitrary value
  localparam logic [15:0] PT = 16'h3C3C; // arbitrary value
  localparam logic [7:0]  RV = 8'h2A;    // arbitrary value
  // {command, d2, io/mem/start/parity}; d2 case last for readback
  localparam logic [167:0] CLM = {24'h000000, 24'h000108, 24'h000204,
    24'h000402, 24'h004001, 24'h01470F, 24'h014710};
  // {cls, words, core, write, enable, command}
  localparam logic [319:0] MST = {32'h0404111F, 32'h04040117,
    32'h04031117, 32'h0408101C, 32'h0404101E, 32'h04031016,
    32'h03081117, 32'h03081016, 32'h00081016, 32'h0404100E};
  // {event, command, sticky status}
  localparam logic [439:0] EVT = {40'h4000000000, 40'h4001004000,
    40'h2001000000, 40'h2001404000, 40'h8000008000, 40'h1800000000,
    40'h1000002000, 40'h0400001000, 40'h0300000000, 40'h0200400000,
    40'h0300400100};

  logic                  clk;
  logic                  rst;
  logic                  cfgValid;
  pcr_pkg::pcr_cfg_req_t cfgReq;
  logic                  cfgAck;
  logic [31:0]           cfgRdata;
  logic                  powerStateD2;
  logic                  coreWriteInvalidateEnable;
  pcr_pkg::pcr_events_t  busEvents;
  logic                  ioHit;
  logic                  memHit;
  logic                  ioClaim;
  logic                  memClaim;
  logic                  masterStartReq;
  logic                  masterIsWrite;
  logic [7:0]            masterWords;
  logic                  masterStart;
  logic [3:0]            masterCmd;
  logic                  masterFrameActive;
  logic                  tenureExpired;
  logic                  parityCheckEn;
  logic                  parityGenEn;
  logic                  serrOut;
  logic                  serrOeN;
  int                    errors;
  int                    samplesChecked;

  pcr_cfg_header #(.FUNC_NUM(3'h0), .ENHANCED(1'b1), .MAKER_CODE(MK),
    .PART_CODE(PT), .REV_CODE(RV)) u_dut (.clk(clk), .rst(rst),
    .cfgValid(cfgValid), .cfgReq(cfgReq), .cfgAck(cfgAck),
    .cfgRdata(cfgRdata), .powerStateD2(powerStateD2),
    .coreWriteInvalidateEnable(coreWriteInvalidateEnable),
    .busEvents(busEvents), .ioHit(ioHit), .memHit(memHit),
    .ioClaim(ioClaim), .memClaim(memClaim),
    .masterStartReq(masterStartReq), .masterIsWrite(masterIsWrite),
    .masterWords(masterWords), .masterStart(masterStart),
    .masterCmd(masterCmd), .masterFrameActive(masterFrameActive),
    .tenureExpired(tenureExpired), .parityCheckEn(parityCheckEn),
    .parityGenEn(parityGenEn), .serrOut(serrOut), .serrOeN(serrOeN));

  pcr_host_model u_host (.clk(clk), .cfgValid(cfgValid), .cfgReq(cfgReq),
    .cfgAck(cfgAck), .cfgRdata(cfgRdata));

  // free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (errors == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // every access to our function must be answered
  task automatic wr(input logic [5:0] dw, input logic [3:0] be,
                    input logic [31:0] d);
    logic        a;
    logic [31:0] r;
    u_host.access(1'b1, 3'h0, dw, be, d, a, r);
    check({31'h0, a}, 32'h1);
  endtask

  task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
    logic        a;
    logic [31:0] r;
    u_host.access(1'b0, 3'h0, dw, 4'hF, 32'h0, a, r);
    check({31'h0, a}, 32'h1);
    check(r, exp);
  endtask

  task automatic mreq(input logic w, input logic [7:0] n);
    @(posedge clk);
    masterStartReq <= 1'b1;
    masterIsWrite  <= w;
    masterWords    <= n;
    @(posedge clk);
    masterStartReq <= 1'b0;
    #1;
  endtask

  // events are single-cycle pulses
  task automatic pulse(input logic [7:0] e);
    @(posedge clk);
    busEvents <= e;
    @(posedge clk);
    busEvents <= '0;
    #1;
  endtask

  // main sequence
  initial begin
    logic        a;
    logic [31:0] r;
    logic [31:0] t;
    logic [31:0] g;
    logic [39:0] v;
    int          k;
    errors = 0;
    samplesChecked = 0;
    rst = 1'b1;
    powerStateD2 = 1'b0;
    coreWriteInvalidateEnable = 1'b0;
    busEvents = '0;
    ioHit = 1'b0;
    memHit = 1'b0;
    masterStartReq = 1'b0;
    masterIsWrite = 1'b0;
    masterWords = 8'h00;
    masterFrameActive = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(6'h00, {PT, MK});
    rd(6'h01, 32'h02100000);
    rd(6'h02, {pcr_pkg::CLASS_VALUE, RV});
    rd(6'h03, 32'h00000000);
    rd(6'h04, 32'h00000000);
    rd(6'h3F, 32'h00000000);
    wr(6'h00, 4'hF, 32'hFFFFFFFF);
    wr(6'h02, 4'hF, 32'hFFFFFFFF);
    wr(6'h04, 4'hF, 32'hFFFFFFFF);
    rd(6'h00, {PT, MK});
    rd(6'h02, {pcr_pkg::CLASS_VALUE, RV});
    rd(6'h04, 32'h00000000);
    wr(6'h01, 4'h3, 32'hFFFFFFFF);
    rd(6'h01, 32'h02100157);
    wr(6'h03, 4'hF, 32'hFFFFFFFF);
    rd(6'h03, 32'h0000FFFF);
    // another function number is not ours
    u_host.access(1'b0, 3'h1, 6'h00, 4'hF, 32'h0, a, r);
    check({31'h0, a}, 32'h0);
    // decode enables, with range hits held throughout
    @(posedge clk);
    ioHit  <= 1'b1;
    memHit <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      t = {8'h0, CLM[(6-i)*24 +: 24]};
      @(posedge clk);
      powerStateD2 <= t[4];
      wr(6'h01, 4'h3, {16'h0, t[23:8]});
      mreq(1'b0, 8'h00);
      g = {28'h0, ioClaim, memClaim, masterStart, parityCheckEn};
      check(g, {28'h0, t[3:0]});
      check({31'h0, parityGenEn}, 32'h1);
    end
    rd(6'h01, 32'h02100147);
    @(posedge clk);
    powerStateD2 <= 1'b0;
    // command choice against line size and burst length
    for (int i = 0; i < 10; i++) begin
      t = MST[(9-i)*32 +: 32];
      @(posedge clk);
      coreWriteInvalidateEnable <= t[12];
      wr(6'h03, 4'h1, {24'h0, t[31:24]});
      wr(6'h01, 4'h3, t[4] ? 32'h14 : 32'h10);
      mreq(t[8], t[23:16]);
      g = {27'h0, masterStart, masterCmd};
      check(g, {27'h0, t[4], t[3:0]});
    end
    // tenure: expiry one cycle past the programmed count
    for (int n = 0; n < 6; n += 5) begin
      wr(6'h03, 4'h2, n << 8);
      @(posedge clk);
      masterFrameActive <= 1'b1;
      k = 0;
      while (k < 20 && tenureExpired !== 1'b1) begin
        @(posedge clk);
        #1;
        k++;
      end
      check(k, n + 1);
      if (k >= 20) tally_and_finish();
      @(posedge clk);
      masterFrameActive <= 1'b0;
      @(posedge clk);
      #1;
      check({31'h0, tenureExpired}, 32'h0);
    end
    // each event under its enables, then a full clear
    for (int i = 0; i < 11; i++) begin
      v = EVT[(10-i)*40 +: 40];
      wr(6'h01, 4'h3, {16'h0, v[31:16]});
      pulse(v[39:32]);
      check({30'h0, serrOeN, serrOut}, {30'h0, ~v[14], 1'b0});
      g = {16'h0210 | v[15:0], v[31:16]};
      rd(6'h01, g);
      wr(6'h01, 4'hC, 32'hFFFF0000);
    end
    // write-one-to-clear leaves other sticky bits alone
    wr(6'h01, 4'h3, 32'h0);
    pulse(8'h80);
    pulse(8'h10);
    wr(6'h01, 4'hC, 32'h80000000);
    rd(6'h01, 32'h22100000);
    wr(6'h01, 4'hC, 32'hFFFF0000);
    rd(6'h01, 32'h02100000);
    tally_and_finish();
  end

endmodule

`default_nettype wire
